// >>> hdl/cssc_params.svh
// Constants of the subtract/shift/control execution block: offsets, fields, opcodes, counts.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
// Contract
// - Select-bank-one 5F, 4 cycles, sets flag bit 0; arithmetic flags unchanged.
// - Subtract-with-borrow stores dst minus src minus carry; opcodes 32 to 36.
// - Subtract stores dst minus src; opcodes 22 to 26; 4 or 6 cycles.
// - Subtract carry set on borrow, subtrahend above minuend, cleared otherwise.
// - Subtract zero flag follows zero result, sign flag follows negative result.
// - Subtract overflow: operands differ in sign, result sign equals source sign.
// - Both subtract forms set the decimal-adjust flag to one.
// - Subtract half-carry cleared on carry out of bit 3, set otherwise.
// - Force-carry DF, 4 cycles, sets carry, no other flag altered.
// - Arithmetic shift right keeps bit 7, shifts down, bit 0 to carry; D0/D1.
// - Shift: carry from bit 0, zero/sign follow result, overflow cleared, D/H kept.
// - Pointer load 31: select 10 loads low pointer bits 7:3, 01 high.
// - Select 00 loads both with bits 7:4; bit 3 low cleared, high set.
// - Stop 7F, 4 cycles, halts clocks and enters stopped state, flags unchanged.
// - While stopped all registers keep their contents.
// - Stopped state left only by external reset or external interrupt.
`ifndef CSSC_PARAMS_SVH
`define CSSC_PARAMS_SVH

`define CSSC_ADDR_CMD       12'h000
`define CSSC_ADDR_DST       12'h004
`define CSSC_ADDR_SRC       12'h008
`define CSSC_ADDR_FLAGS     12'h00C
`define CSSC_ADDR_STATUS    12'h010
`define CSSC_IDX_PTR_LOW    10'h0D6
`define CSSC_IDX_PTR_HIGH   10'h0D7

`define CSSC_FLAG_C         7
`define CSSC_FLAG_Z         6
`define CSSC_FLAG_S         5
`define CSSC_FLAG_V         4
`define CSSC_FLAG_D         3
`define CSSC_FLAG_H         2
`define CSSC_FLAG_BANK      0

`define CSSC_STAT_BUSY      0
`define CSSC_STAT_STOPPED   1
`define CSSC_STAT_BADOP     2

`define CSSC_OP_BANK_ONE    8'h5F
`define CSSC_OP_BSUB_FIRST  8'h32
`define CSSC_OP_BSUB_LAST   8'h36
`define CSSC_OP_SUB_FIRST   8'h22
`define CSSC_OP_SUB_LAST    8'h26
`define CSSC_OP_FORCE_C     8'hDF
`define CSSC_OP_ASHR_R      8'hD0
`define CSSC_OP_ASHR_IR     8'hD1
`define CSSC_OP_PTR_LOAD    8'h31
`define CSSC_OP_STOP        8'h7F

`define CSSC_PTR_SEL_BOTH   2'h0
`define CSSC_PTR_SEL_HIGH   2'h1
`define CSSC_PTR_SEL_LOW    2'h2
`define CSSC_PTR_SEL_NONE   2'h3

`define CSSC_CYC_SHORT      3'h4
`define CSSC_CYC_LONG       3'h6

`define CSSC_FLAGS_RST      8'h00
`define CSSC_PTR_RST        8'h00

`endif

// >>> hdl/cssc_pkg.sv
// Types of the subtract/shift/control execution block.
// Assumes nothing of its surroundings.
package cssc_pkg;

  typedef enum logic [2:0] {
    CSSC_IDLE    = 3'b001,
    CSSC_EXEC    = 3'b010,
    CSSC_STOPPED = 3'b100
  } cssc_state_type;

  typedef struct packed {
    cssc_state_type st;
    logic [2:0]     cnt;
    logic [7:0]     op;
    logic [7:0]     dst;
    logic [7:0]     src;
    logic [7:0]     flags;
    logic [7:0]     ptr_low;
    logic [7:0]     ptr_high;
    logic           bad_op;
    logic           int_meta;
    logic           int_sync;
    logic [31:0]    rdata;
  } cssc_regs_type;

endpackage

// >>> hdl/cssc_sub_shift_alu.sv
// Combinational subtract and arithmetic-shift unit with flag generation.
// Assumes the caller picks the operation and registers the outputs.
`timescale 1ns/1ps
`default_nettype none
`include "cssc_params.svh"

module cssc_sub_shift_alu
(
  input  wire logic       shift_sel_in,
  input  wire logic       borrow_sel_in,
  input  wire logic [7:0] dst_in,
  input  wire logic [7:0] src_in,
  input  wire logic [7:0] flags_in,
  output logic      [7:0] res_out,
  output logic      [7:0] flags_out
);

  always_comb
  begin
    logic       borrow_in;
    logic [8:0] diff;
    logic [4:0] nib_diff;
    borrow_in = borrow_sel_in & flags_in[`CSSC_FLAG_C];
    diff      = {1'b0, dst_in} - {1'b0, src_in} - {8'h00, borrow_in};
    nib_diff  = {1'b0, dst_in[3:0]} - {1'b0, src_in[3:0]} - {4'h0, borrow_in};
    res_out   = diff[7:0];
    flags_out = flags_in;
    if (shift_sel_in)
    begin
      res_out = {dst_in[7], dst_in[7:1]};
      flags_out[`CSSC_FLAG_C] = dst_in[0];
      flags_out[`CSSC_FLAG_Z] = ({dst_in[7], dst_in[7:1]} == 8'h00);
      flags_out[`CSSC_FLAG_S] = dst_in[7];
      flags_out[`CSSC_FLAG_V] = 1'b0;
    end
    else
    begin
      flags_out[`CSSC_FLAG_C] = diff[8];
      flags_out[`CSSC_FLAG_Z] = (diff[7:0] == 8'h00);
      flags_out[`CSSC_FLAG_S] = diff[7];
      flags_out[`CSSC_FLAG_V] = (dst_in[7] ^ src_in[7]) & ~(diff[7] ^ src_in[7]);
      flags_out[`CSSC_FLAG_D] = 1'b1;
      flags_out[`CSSC_FLAG_H] = nib_diff[4];
    end
  end

endmodule
`default_nettype wire

// >>> hdl/cssc_exec_top.sv
// Execution unit for bank select, subtract, force-carry, arithmetic shift, pointer load, stop.
// Assumes an APB master on CORE_CLK_IN and an asynchronous external interrupt level.
`timescale 1ns/1ps
`default_nettype none
`include "cssc_params.svh"

module cssc_exec_top
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic        EXT_INT_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic             CLK_HALT_OUT,
  output logic             BANK_SEL_OUT,
  output logic      [7:0]  PTR_LOW_OUT,
  output logic      [7:0]  PTR_HIGH_OUT
);

  localparam logic [11:0] ADDR_PTR_LOW  = {`CSSC_IDX_PTR_LOW, 2'b00};
  localparam logic [11:0] ADDR_PTR_HIGH = {`CSSC_IDX_PTR_HIGH, 2'b00};

  cssc_pkg::cssc_regs_type cur_q;
  cssc_pkg::cssc_regs_type nxt_d;

  logic       busy;
  logic       stopped;
  logic       mapped;
  logic       access;
  logic       wr_ok;
  logic       commit;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;

  function automatic logic is_bsub(input logic [7:0] op);
    is_bsub = (op >= `CSSC_OP_BSUB_FIRST) && (op <= `CSSC_OP_BSUB_LAST);
  endfunction

  function automatic logic is_sub(input logic [7:0] op);
    is_sub = (op >= `CSSC_OP_SUB_FIRST) && (op <= `CSSC_OP_SUB_LAST);
  endfunction

  function automatic logic is_ashr(input logic [7:0] op);
    is_ashr = (op == `CSSC_OP_ASHR_R) || (op == `CSSC_OP_ASHR_IR);
  endfunction

  // Zero marks an opcode this unit does not execute
  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    if ((op == `CSSC_OP_SUB_FIRST) || (op == `CSSC_OP_BSUB_FIRST))
      op_cycles = `CSSC_CYC_SHORT;
    else if (is_sub(op) || is_bsub(op))
      op_cycles = `CSSC_CYC_LONG;
    else if ((op == `CSSC_OP_BANK_ONE) || (op == `CSSC_OP_FORCE_C) ||
             (op == `CSSC_OP_PTR_LOAD) || (op == `CSSC_OP_STOP) || is_ashr(op))
      op_cycles = `CSSC_CYC_SHORT;
    else
      op_cycles = 3'h0;
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = (addr == `CSSC_ADDR_CMD) || (addr == `CSSC_ADDR_DST) ||
                  (addr == `CSSC_ADDR_SRC) || (addr == `CSSC_ADDR_FLAGS) ||
                  (addr == `CSSC_ADDR_STATUS) || (addr == ADDR_PTR_LOW) ||
                  (addr == ADDR_PTR_HIGH);
  endfunction

  cssc_sub_shift_alu u_alu
  (
    .shift_sel_in  (is_ashr(cur_q.op)),
    .borrow_sel_in (is_bsub(cur_q.op)),
    .dst_in        (cur_q.dst),
    .src_in        (cur_q.src),
    .flags_in      (cur_q.flags),
    .res_out       (alu_res),
    .flags_out     (alu_flags)
  );

  assign busy    = (cur_q.st == cssc_pkg::CSSC_EXEC);
  assign stopped = (cur_q.st == cssc_pkg::CSSC_STOPPED);
  assign mapped  = addr_mapped(PADDR_IN);
  assign access  = PSEL_IN && PENABLE_IN && !busy;
  // stopped refuses writes
  // Clock halted: register writes are refused, reads still show retained state
  assign wr_ok   = access && PWRITE_IN && mapped && !stopped &&
                   (PADDR_IN != `CSSC_ADDR_STATUS);
  assign commit  = busy && (cur_q.cnt == 3'h0);

  always_comb
  begin
    nxt_d          = cur_q;
    nxt_d.int_meta = EXT_INT_IN;
    nxt_d.int_sync = cur_q.int_meta;
    unique case (cur_q.st)
      cssc_pkg::CSSC_IDLE:
      begin
        if (wr_ok)
        begin
          unique case (PADDR_IN)
            `CSSC_ADDR_CMD:
            begin
              if (op_cycles(PWDATA_IN[7:0]) != 3'h0)
              begin
                nxt_d.st     = cssc_pkg::CSSC_EXEC;
                nxt_d.cnt    = op_cycles(PWDATA_IN[7:0]) - 3'h1;
                nxt_d.op     = PWDATA_IN[7:0];
                nxt_d.bad_op = 1'b0;
              end
              else
              begin
                nxt_d.bad_op = 1'b1;
              end
            end
            `CSSC_ADDR_DST:   nxt_d.dst      = PWDATA_IN[7:0];
            `CSSC_ADDR_SRC:   nxt_d.src      = PWDATA_IN[7:0];
            `CSSC_ADDR_FLAGS: nxt_d.flags    = PWDATA_IN[7:0];
            ADDR_PTR_LOW:     nxt_d.ptr_low  = PWDATA_IN[7:0];
            ADDR_PTR_HIGH:    nxt_d.ptr_high = PWDATA_IN[7:0];
            default:          nxt_d.bad_op   = cur_q.bad_op;
          endcase
        end
      end
      cssc_pkg::CSSC_EXEC:
      begin
        if (!commit)
        begin
          nxt_d.cnt = cur_q.cnt - 3'h1;
        end
        else
        begin
          nxt_d.st = cssc_pkg::CSSC_IDLE;
          if (cur_q.op == `CSSC_OP_BANK_ONE)
          begin
            nxt_d.flags[`CSSC_FLAG_BANK] = 1'b1;
          end
          else if (cur_q.op == `CSSC_OP_FORCE_C)
          begin
            nxt_d.flags[`CSSC_FLAG_C] = 1'b1;
          end
          else if (cur_q.op == `CSSC_OP_STOP)
          begin
            nxt_d.st = cssc_pkg::CSSC_STOPPED;
          end
          else if (cur_q.op == `CSSC_OP_PTR_LOAD)
          begin
            unique case (cur_q.src[1:0])
              `CSSC_PTR_SEL_LOW:  nxt_d.ptr_low[7:3]  = cur_q.src[7:3];
              `CSSC_PTR_SEL_HIGH: nxt_d.ptr_high[7:3] = cur_q.src[7:3];
              `CSSC_PTR_SEL_BOTH:
              begin
                nxt_d.ptr_low[7:3]  = {cur_q.src[7:4], 1'b0};
                nxt_d.ptr_high[7:3] = {cur_q.src[7:4], 1'b1};
              end
              default: nxt_d.ptr_low = cur_q.ptr_low;
            endcase
          end
          else
          begin
            nxt_d.dst   = alu_res;
            nxt_d.flags = alu_flags;
          end
        end
      end
      cssc_pkg::CSSC_STOPPED:
      begin
        if (cur_q.int_sync)
        begin
          nxt_d.st = cssc_pkg::CSSC_IDLE;
        end
      end
      default: nxt_d.st = cssc_pkg::CSSC_IDLE;
    endcase
    // Read data tracks the state that the access cycle will see
    unique case (PADDR_IN)
      `CSSC_ADDR_DST:    nxt_d.rdata = {24'h000000, nxt_d.dst};
      `CSSC_ADDR_SRC:    nxt_d.rdata = {24'h000000, nxt_d.src};
      `CSSC_ADDR_FLAGS:  nxt_d.rdata = {24'h000000, nxt_d.flags};
      `CSSC_ADDR_STATUS:
      begin
        nxt_d.rdata                     = 32'h00000000;
        nxt_d.rdata[`CSSC_STAT_BUSY]    = (nxt_d.st == cssc_pkg::CSSC_EXEC);
        nxt_d.rdata[`CSSC_STAT_STOPPED] = (nxt_d.st == cssc_pkg::CSSC_STOPPED);
        nxt_d.rdata[`CSSC_STAT_BADOP]   = nxt_d.bad_op;
      end
      ADDR_PTR_LOW:      nxt_d.rdata = {24'h000000, nxt_d.ptr_low};
      ADDR_PTR_HIGH:     nxt_d.rdata = {24'h000000, nxt_d.ptr_high};
      default:           nxt_d.rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      cur_q <= '{st: cssc_pkg::CSSC_IDLE, flags: `CSSC_FLAGS_RST, ptr_low: `CSSC_PTR_RST,
                 ptr_high: `CSSC_PTR_RST, default: '0};
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  // Wait states while an instruction executes
  assign PREADY_OUT   = !busy;
  assign PSLVERR_OUT  = access && (!mapped || (PWRITE_IN && !wr_ok));
  assign PRDATA_OUT   = cur_q.rdata;
  assign CLK_HALT_OUT = stopped;
  assign BANK_SEL_OUT = cur_q.flags[`CSSC_FLAG_BANK];
  assign PTR_LOW_OUT  = cur_q.ptr_low;
  assign PTR_HIGH_OUT = cur_q.ptr_high;

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  chk_bank_one_set: assert property (
    commit && (cur_q.op == `CSSC_OP_BANK_ONE) |=>
      cur_q.flags[`CSSC_FLAG_BANK] && (cur_q.flags[7:1] == $past(cur_q.flags[7:1])))
    else $error("bank select did not set bank flag alone");

  chk_bsub_result: assert property (
    commit && is_bsub(cur_q.op) |=>
      cur_q.dst == ($past(cur_q.dst) - $past(cur_q.src) -
                    {7'h00, $past(cur_q.flags[`CSSC_FLAG_C])}))
    else $error("borrow subtract result wrong");

  chk_sub_long_cycles: assert property (
    wr_ok && (PADDR_IN == `CSSC_ADDR_CMD) && (PWDATA_IN[7:0] == 8'h24) |=>
      busy [*6] ##1 !busy)
    else $error("register subtract did not take six cycles");

  chk_sub_borrow: assert property (
    commit && is_sub(cur_q.op) |=>
      cur_q.flags[`CSSC_FLAG_C] == ($past(cur_q.src) > $past(cur_q.dst)))
    else $error("subtract carry not equal to borrow");

  chk_sub_zero_sign: assert property (
    commit && (is_sub(cur_q.op) || is_bsub(cur_q.op)) |=>
      (cur_q.flags[`CSSC_FLAG_Z] == (cur_q.dst == 8'h00)) &&
      (cur_q.flags[`CSSC_FLAG_S] == cur_q.dst[7]))
    else $error("subtract zero or sign flag wrong");

  chk_sub_overflow: assert property (
    commit && is_sub(cur_q.op) |=>
      cur_q.flags[`CSSC_FLAG_V] == (($past(cur_q.dst[7]) != $past(cur_q.src[7])) &&
                                    (cur_q.dst[7] == $past(cur_q.src[7]))))
    else $error("subtract overflow flag wrong");

  chk_sub_decimal: assert property (
    commit && (is_sub(cur_q.op) || is_bsub(cur_q.op)) |=> cur_q.flags[`CSSC_FLAG_D])
    else $error("subtract left decimal flag clear");

  chk_sub_half: assert property (
    commit && is_sub(cur_q.op) |=>
      cur_q.flags[`CSSC_FLAG_H] == ($past(cur_q.dst[3:0]) < $past(cur_q.src[3:0])))
    else $error("subtract half-carry flag wrong");

  chk_carry_force: assert property (
    commit && (cur_q.op == `CSSC_OP_FORCE_C) |=>
      cur_q.flags[`CSSC_FLAG_C] && (cur_q.flags[6:0] == $past(cur_q.flags[6:0])))
    else $error("force carry changed other flags or failed");

  chk_shift_value: assert property (
    commit && is_ashr(cur_q.op) |=>
      (cur_q.dst == {$past(cur_q.dst[7]), $past(cur_q.dst[7:1])}) &&
      (cur_q.flags[`CSSC_FLAG_C] == $past(cur_q.dst[0])))
    else $error("arithmetic shift result wrong");

  chk_shift_flags: assert property (
    commit && is_ashr(cur_q.op) |=>
      !cur_q.flags[`CSSC_FLAG_V] && $stable(cur_q.flags[3:2]) &&
      (cur_q.flags[`CSSC_FLAG_Z] == (cur_q.dst == 8'h00)))
    else $error("arithmetic shift flags wrong");

  chk_ptr_single: assert property (
    commit && (cur_q.op == `CSSC_OP_PTR_LOAD) && (cur_q.src[1:0] == `CSSC_PTR_SEL_LOW) |=>
      (cur_q.ptr_low[7:3] == $past(cur_q.src[7:3])) && $stable(cur_q.ptr_high))
    else $error("low pointer load wrong");

  chk_ptr_both: assert property (
    commit && (cur_q.op == `CSSC_OP_PTR_LOAD) && (cur_q.src[1:0] == `CSSC_PTR_SEL_BOTH) |=>
      !cur_q.ptr_low[3] && cur_q.ptr_high[3] && $stable(cur_q.flags) &&
      (cur_q.ptr_high[7:4] == $past(cur_q.src[7:4])))
    else $error("dual pointer load wrong");

  chk_ptr_undefined: assert property (
    commit && (cur_q.op == `CSSC_OP_PTR_LOAD) && (cur_q.src[1:0] == `CSSC_PTR_SEL_NONE) |=>
      $stable(cur_q.ptr_low) && $stable(cur_q.ptr_high))
    else $error("undefined pointer select changed a pointer");

  chk_stop_entry: assert property (
    commit && (cur_q.op == `CSSC_OP_STOP) |=> CLK_HALT_OUT && $stable(cur_q.flags))
    else $error("stop did not halt or changed flags");

  chk_stop_retain: assert property (
    stopped |=> $stable(cur_q.dst) && $stable(cur_q.src) && $stable(cur_q.flags) &&
                $stable(cur_q.ptr_low) && $stable(cur_q.ptr_high))
    else $error("state changed while stopped");

  chk_stop_exit: assert property (
    stopped && !cur_q.int_sync |=> stopped)
    else $error("stopped state left without wake event");

  chk_sub_short_cycles: assert property (
    wr_ok && (PADDR_IN == `CSSC_ADDR_CMD) && (PWDATA_IN[7:0] == `CSSC_OP_SUB_FIRST) |=>
      busy [*4] ##1 !busy)
    else $error("register pair subtract did not take four cycles");

  chk_bsub_borrow: assert property (
    commit && is_bsub(cur_q.op) |=>
      cur_q.flags[`CSSC_FLAG_C] ==
        (({1'b0, $past(cur_q.src)} + {8'h00, $past(cur_q.flags[`CSSC_FLAG_C])}) >
         {1'b0, $past(cur_q.dst)}))
    else $error("borrow subtract carry not equal to borrow");

  chk_bsub_half: assert property (
    commit && is_bsub(cur_q.op) |=>
      cur_q.flags[`CSSC_FLAG_H] ==
        (({1'b0, $past(cur_q.src[3:0])} + {4'h0, $past(cur_q.flags[`CSSC_FLAG_C])}) >
         {1'b0, $past(cur_q.dst[3:0])}))
    else $error("borrow subtract half-carry flag wrong");

  chk_bsub_overflow: assert property (
    commit && is_bsub(cur_q.op) |=>
      cur_q.flags[`CSSC_FLAG_V] == (($past(cur_q.dst[7]) != $past(cur_q.src[7])) &&
                                    (cur_q.dst[7] == $past(cur_q.src[7]))))
    else $error("borrow subtract overflow flag wrong");

  chk_ptr_high_load: assert property (
    commit && (cur_q.op == `CSSC_OP_PTR_LOAD) && (cur_q.src[1:0] == `CSSC_PTR_SEL_HIGH) |=>
      (cur_q.ptr_high[7:3] == $past(cur_q.src[7:3])) && $stable(cur_q.ptr_low))
    else $error("high pointer load wrong");

  chk_stop_write_err: assert property (
    stopped && PSEL_IN && PENABLE_IN && PWRITE_IN |-> PSLVERR_OUT && PREADY_OUT)
    else $error("write while stopped not refused");

endmodule
`default_nettype wire

// >>> tb/cssc_exec_top_test.sv
// Self-checking bench for the subtract, shift and control execution unit.
// Assumes the unit's APB register map and a 25 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "cssc_params.svh"

module cssc_exec_top_test;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        ext_int;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        halt;
  logic        bank;
  logic [7:0]  ptr_lo;
  logic [7:0]  ptr_hi;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          n_compared;

  localparam logic [11:0] a_cmd = `CSSC_ADDR_CMD;
  localparam logic [11:0] a_dst = `CSSC_ADDR_DST;
  localparam logic [11:0] a_src = `CSSC_ADDR_SRC;
  localparam logic [11:0] a_flg = `CSSC_ADDR_FLAGS;
  localparam logic [11:0] a_sta = `CSSC_ADDR_STATUS;
  localparam logic [11:0] a_lo  = {`CSSC_IDX_PTR_LOW, 2'b00};
  localparam logic [11:0] a_hi  = {`CSSC_IDX_PTR_HIGH, 2'b00};

  logic [7:0] dv [5] = '{8'h12, 8'h21, 8'h21, 8'h20, 8'h55};
  logic [7:0] sv [5] = '{8'h03, 8'h90, 8'h65, 8'h8A, 8'h55};
  logic [7:0] sd [3] = '{8'h9A, 8'hBC, 8'h01};
  logic [7:0] sf [3] = '{8'h9C, 8'h00, 8'h03};
  logic [7:0] sr [3] = '{8'hCD, 8'hDE, 8'h00};
  logic [7:0] se [3] = '{8'h2C, 8'h20, 8'hC3};

  cssc_exec_top i_dut
  (
    .CORE_CLK_IN  (clk),
    .RST_IN       (rst),
    .PSEL_IN      (psel),
    .PENABLE_IN   (pen),
    .PWRITE_IN    (pwr),
    .PADDR_IN     (paddr),
    .PWDATA_IN    (pwdata),
    .EXT_INT_IN   (ext_int),
    .PRDATA_OUT   (prdata),
    .PREADY_OUT   (pready),
    .PSLVERR_OUT  (pslverr),
    .CLK_HALT_OUT (halt),
    .BANK_SEL_OUT (bank),
    .PTR_LOW_OUT  (ptr_lo),
    .PTR_HIGH_OUT (ptr_hi)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 40)
    begin
      check("pready wait", 32'h0, 32'h1);
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(what, rd, {24'h000000, e});
  endtask

  // Issues an opcode and counts the busy cycles that follow
  task automatic run(input logic [7:0] op, input int cyc);
    int n;
    xfer(1'b1, a_cmd, op);
    n = 0;
    repeat (20)
    begin
      @(posedge clk);
      if (pready !== 1'b0)
        break;
      n++;
    end
    check("busy cycles", n, cyc);
  endtask

  task automatic ptrs(input logic [7:0] lo, input logic [7:0] hi);
    check("low pointer pin", ptr_lo, lo);
    check("high pointer pin", ptr_hi, hi);
    rchk("low pointer", a_lo, lo);
    rchk("high pointer", a_hi, hi);
  endtask

  function automatic logic [15:0] sub_model(input logic [7:0] d, input logic [7:0] s,
                                            input logic ci, input logic [7:0] f);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] o;
    r = {1'b0, d} - {1'b0, s} - {8'h00, ci};
    h = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, ci};
    o = f;
    o[7] = r[8];
    o[6] = (r[7:0] == 8'h00);
    o[5] = r[7];
    o[4] = (d[7] != s[7]) && (r[7] == s[7]);
    o[3] = 1'b1;
    o[2] = h[4];
    return {r[7:0], o};
  endfunction

  initial
  begin
    logic [7:0]  op;
    logic [7:0]  f;
    logic [15:0] e;
    int          n;
    n_mismatch = 0;
    n_compared = 0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ext_int = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk("flags after reset", a_flg, 8'h00);
    rchk("status after reset", a_sta, 8'h00);
    ptrs(8'h00, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      op = (i < 5 ? 8'h22 : 8'h32) + 8'(i % 5);
      f = (i % 2 == 1) ? 8'h87 : 8'h02;
      e = sub_model(dv[i % 5], sv[i % 5], (i >= 5) && f[7], f);
      wr(a_dst, dv[i % 5]);
      wr(a_src, sv[i % 5]);
      wr(a_flg, f);
      run(op, (i % 5 == 0) ? 4 : 6);
      rchk("sub result", a_dst, e[15:8]);
      rchk("sub flags", a_flg, e[7:0]);
      rchk("sub source", a_src, sv[i % 5]);
    end
    wr(a_dst, 8'h21);
    wr(a_src, 8'h03);
    wr(a_cmd, 8'h24);
    rchk("stalled sub result", a_dst, 8'h1E);
    wr(a_flg, 8'hA4);
    run(8'h5F, 4);
    rchk("bank flags", a_flg, 8'hA5);
    check("bank pin", bank, 32'h1);
    wr(a_flg, 8'h00);
    run(8'hDF, 4);
    rchk("carry set", a_flg, 8'h80);
    wr(a_flg, 8'h7D);
    run(8'hDF, 4);
    rchk("carry others", a_flg, 8'hFD);
    for (int k = 0; k < 3; k++)
    begin
      wr(a_dst, sd[k]);
      wr(a_flg, sf[k]);
      run(k == 2 ? 8'hD1 : 8'hD0, 4);
      rchk("shift result", a_dst, sr[k]);
      rchk("shift flags", a_flg, se[k]);
    end
    wr(a_flg, 8'h5A);
    wr(a_src, 8'h40);
    run(8'h31, 4);
    ptrs(8'h40, 8'h48);
    wr(a_src, 8'h52);
    run(8'h31, 4);
    ptrs(8'h50, 8'h48);
    wr(a_src, 8'h69);
    run(8'h31, 4);
    ptrs(8'h50, 8'h68);
    wr(a_src, 8'hFB);
    run(8'h31, 4);
    ptrs(8'h50, 8'h68);
    rchk("pointer flags", a_flg, 8'h5A);
    wr(a_dst, 8'h33);
    run(8'h00, 0);
    check("bad opcode error", err, 32'h0);
    rchk("bad opcode status", a_sta, 8'h04);
    rchk("bad opcode dst", a_dst, 8'h33);
    xfer(1'b0, 12'h020, 8'h00);
    check("unmapped error", err, 32'h1);
    check("unmapped data", rd, 32'h0);
    wr(a_sta, 8'h07);
    check("status write error", err, 32'h1);
    wr(a_dst, 8'hA7);
    wr(a_flg, 8'h5A);
    run(8'h7F, 4);
    check("halt", halt, 32'h1);
    repeat (30) @(posedge clk);
    check("halt held", halt, 32'h1);
    wr(a_dst, 8'h11);
    check("stopped write error", err, 32'h1);
    rchk("stopped status", a_sta, 8'h02);
    rchk("stopped dst", a_dst, 8'hA7);
    rchk("stopped flags", a_flg, 8'h5A);
    @(posedge clk);
    ext_int <= 1'b1;
    n = 0;
    while (halt !== 1'b0 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    check("interrupt wake", halt, 32'h0);
    ext_int <= 1'b0;
    rchk("woken dst", a_dst, 8'hA7);
    ptrs(8'h50, 8'h68);
    run(8'h7F, 4);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset wake", halt, 32'h0);
    ptrs(8'h00, 8'h00);
    rchk("flags after wake", a_flg, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
